// file: rtl/besm_pkg.sv
package besm_pkg;

    // Register offsets on the fieldbus
    localparam logic [15:0] ADDR_CURRENT_EXCITE_AMPLITUDE   = 16'h002a;
    localparam logic [15:0] ADDR_INJECTION_POINT_SELECT     = 16'h002c;
    localparam logic [15:0] ADDR_OVERCURRENT_DURATION_LIMIT = 16'h0510;
    localparam logic [15:0] ADDR_OVERCURRENT_THRESHOLD      = 16'h0512;

    // Currents in mA, times in ms
    localparam logic signed [31:0] CURRENT_EXCITE_RESET = 32'sh000000c8;
    localparam logic [7:0]         INJECT_RESET         = 8'h00;
    localparam logic [31:0]        LIMIT_RESET          = 32'h00000000;
    localparam logic signed [31:0] THRESH_RESET         = 32'sh00000000;
    localparam logic [31:0]        LIMIT_MIN_MS         = 32'h00000001;
    localparam logic [31:0]        LIMIT_MAX_MS         = 32'h0000ea60;
    localparam logic signed [31:0] THRESH_MIN_MA        = 32'sh00000001;

    localparam logic [7:0] INJECT_NONE     = 8'h00;
    localparam logic [7:0] INJECT_CURRENT  = 8'h01;
    localparam logic [7:0] INJECT_VELOCITY = 8'h02;

    localparam logic [7:0] MODE_PRB       = 8'h01;
    localparam logic [7:0] MODE_STABILITY = 8'h05;

    localparam logic [7:0] FAULT_INSTABILITY = 8'h85;

    // Drive samples per millisecond (16 kHz sample rate)
    localparam int unsigned SAMPLE_RATE_HZ = 16000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam logic [31:0] SAMPLES_PER_MS = 32'(SAMPLE_RATE_HZ / MS_PER_S);

    // Waveform is Q1.15, full scale means one peak amplitude
    localparam int unsigned WAVE_FRAC = 15;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } besm_reg_req_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        rvalid;
    } besm_reg_rsp_s;

    typedef struct packed {
        logic signed [31:0] current_amp;
        logic [7:0]         inject;
        logic [31:0]        limit_ms;
        logic signed [31:0] thresh;
        logic [31:0]        over_count;
        logic [7:0]         mode_prev;
        logic               fault;
        logic [7:0]         fault_code;
        logic signed [31:0] peak_amp;
        logic signed [31:0] current_cmd_out;
        logic               inj_current;
        logic               inj_velocity;
        besm_reg_rsp_s      rsp;
    } besm_state_s;

endpackage

// file: rtl/besm_monitor.sv
// Behaviour
// - Current amplitude is peak when current-loop injection
// - Mode 1, inject 1: scale added current
// - Amplitude defaults 0.2 A, clamped to limit
// - Mode 5 accumulates time above threshold
// - Count reaching limit raises fault 133
// - Duration limit in ms, 1 to 60000
// - Threshold in mA, 1 to lower peak
// - Fault time scales with duration limit
// - Injection select 0/1/2, others refused
// - Peak amplitude chosen by injection select
`timescale 1ns/10ps
module besm_monitor (
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    input  wire besm_pkg::besm_reg_req_s reg_req_i,
    output besm_pkg::besm_reg_rsp_s      reg_rsp_o,
    input  wire logic [7:0]              excite_mode_i,
    input  wire logic                    sample_tick_i,
    input  wire logic signed [15:0]      excite_wave_i,
    input  wire logic signed [31:0]      velocity_excite_amplitude_i,
    input  wire logic signed [31:0]      commanded_current_i,
    input  wire logic signed [31:0]      combined_current_limit_i,
    input  wire logic signed [31:0]      drive_peak_current_i,
    input  wire logic signed [31:0]      motor_peak_current_i,
    input  wire logic                    fault_clear_i,
    output logic signed [31:0]           peak_amplitude_o,
    output logic signed [31:0]           current_cmd_o,
    output logic                         inject_current_o,
    output logic                         inject_velocity_o,
    output logic                         instability_fault_o,
    output logic [7:0]                   fault_code_o,
    output logic [31:0]                  overcurrent_count_o
);
    import besm_pkg::*;

    besm_state_s s_q;
    besm_state_s s_d;

    logic signed [31:0] peak_min;
    logic signed [31:0] neg_limit;
    logic signed [31:0] wdata_s;
    logic signed [31:0] cmd_abs;
    logic signed [47:0] product;
    logic [31:0]        limit_samples;
    logic               over;

    always_comb begin
        peak_min      = (drive_peak_current_i < motor_peak_current_i) ?
                        drive_peak_current_i : motor_peak_current_i;
        neg_limit     = -combined_current_limit_i;
        wdata_s       = reg_req_i.wdata;
        cmd_abs       = commanded_current_i[31] ? -commanded_current_i : commanded_current_i;
        product       = s_q.current_amp * excite_wave_i;
        limit_samples = s_q.limit_ms * SAMPLES_PER_MS;
        over          = cmd_abs > s_q.thresh;

        s_d            = s_q;
        s_d.rsp.rvalid = 1'b0;
        s_d.mode_prev  = excite_mode_i;

        if (reg_req_i.we) begin
            unique case (reg_req_i.addr)
                ADDR_CURRENT_EXCITE_AMPLITUDE: begin
                    // Out-of-range writes saturate rather than being refused
                    if (wdata_s > combined_current_limit_i) begin
                        s_d.current_amp = combined_current_limit_i;
                    end else if (wdata_s < neg_limit) begin
                        s_d.current_amp = neg_limit;
                    end else begin
                        s_d.current_amp = wdata_s;
                    end
                end
                ADDR_INJECTION_POINT_SELECT: begin
                    if (reg_req_i.wdata[7:0] <= INJECT_VELOCITY &&
                        reg_req_i.wdata[31:8] == 24'h000000) begin
                        s_d.inject = reg_req_i.wdata[7:0];
                    end
                end
                ADDR_OVERCURRENT_DURATION_LIMIT: begin
                    if (reg_req_i.wdata < LIMIT_MIN_MS) begin
                        s_d.limit_ms = LIMIT_MIN_MS;
                    end else if (reg_req_i.wdata > LIMIT_MAX_MS) begin
                        s_d.limit_ms = LIMIT_MAX_MS;
                    end else begin
                        s_d.limit_ms = reg_req_i.wdata;
                    end
                end
                ADDR_OVERCURRENT_THRESHOLD: begin
                    if (wdata_s < THRESH_MIN_MA) begin
                        s_d.thresh = THRESH_MIN_MA;
                    end else if (wdata_s > peak_min) begin
                        s_d.thresh = peak_min;
                    end else begin
                        s_d.thresh = wdata_s;
                    end
                end
                default: begin
                end
            endcase
        end

        if (reg_req_i.re) begin
            s_d.rsp.rvalid = 1'b1;
            unique case (reg_req_i.addr)
                ADDR_CURRENT_EXCITE_AMPLITUDE:   s_d.rsp.rdata = s_q.current_amp;
                ADDR_INJECTION_POINT_SELECT:     s_d.rsp.rdata = {24'h000000, s_q.inject};
                ADDR_OVERCURRENT_DURATION_LIMIT: s_d.rsp.rdata = s_q.limit_ms;
                ADDR_OVERCURRENT_THRESHOLD:      s_d.rsp.rdata = s_q.thresh;
                default:                         s_d.rsp.rdata = 32'h00000000;
            endcase
        end

        s_d.inj_current  = (s_q.inject == INJECT_CURRENT);
        s_d.inj_velocity = (s_q.inject == INJECT_VELOCITY);
        unique case (s_q.inject)
            INJECT_CURRENT:  s_d.peak_amp = s_q.current_amp;
            INJECT_VELOCITY: s_d.peak_amp = velocity_excite_amplitude_i;
            default:         s_d.peak_amp = 32'sh00000000;
        endcase

        if (excite_mode_i == MODE_PRB && s_q.inject == INJECT_CURRENT) begin
            s_d.current_cmd_out = commanded_current_i + product[WAVE_FRAC +: 32];
        end else begin
            s_d.current_cmd_out = commanded_current_i;
        end

        // A zero limit (reset default) leaves the monitor unarmed
        if (excite_mode_i != MODE_STABILITY) begin
            s_d.over_count = 32'h00000000;
        end else if (sample_tick_i && over && s_q.over_count < limit_samples) begin
            s_d.over_count = s_q.over_count + 32'h00000001;
        end

        if (fault_clear_i) begin
            s_d.fault = 1'b0;
        end
        // Set after clear so a coincident event is not lost
        if (excite_mode_i == MODE_STABILITY && s_q.limit_ms != LIMIT_RESET &&
            s_q.over_count >= limit_samples) begin
            s_d.fault      = 1'b1;
            s_d.fault_code = FAULT_INSTABILITY;
        end
        if (!s_d.fault) begin
            s_d.fault_code = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q                 <= '0;
            s_q.current_amp     <= CURRENT_EXCITE_RESET;
            s_q.inject          <= INJECT_RESET;
            s_q.limit_ms        <= LIMIT_RESET;
            s_q.thresh          <= THRESH_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rsp_o           = s_q.rsp;
    assign peak_amplitude_o    = s_q.peak_amp;
    assign current_cmd_o       = s_q.current_cmd_out;
    assign inject_current_o    = s_q.inj_current;
    assign inject_velocity_o   = s_q.inj_velocity;
    assign instability_fault_o = s_q.fault;
    assign fault_code_o        = s_q.fault_code;
    assign overcurrent_count_o = s_q.over_count;

endmodule

// file: testbench/besm_monitor_props.sv
`timescale 1ns/10ps
module besm_monitor_chk
    import besm_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          resetn_i,
    input wire besm_reg_req_s reg_req_i,
    input wire besm_reg_rsp_s reg_rsp_o,
    input wire logic [7:0]    excite_mode_i,
    input wire logic          sample_tick_i,
    input wire logic          fault_clear_i,
    input wire logic [31:0]   peak_amplitude_o,
    input wire logic          inject_current_o,
    input wire logic          inject_velocity_o,
    input wire logic          instability_fault_o,
    input wire logic [7:0]    fault_code_o,
    input wire logic [31:0]   overcurrent_count_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rd_answer; reg_req_i.re |=> reg_rsp_o.rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_code; instability_fault_o |-> fault_code_o == FAULT_INSTABILITY; endproperty
    a_code: assert property (p_code) else $error("fault code wrong");
    property p_clear; excite_mode_i != MODE_STABILITY |=> overcurrent_count_o == 0; endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");
    property p_hold; !sample_tick_i |=> $stable(overcurrent_count_o) || overcurrent_count_o == 0;
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without sample");
    property p_step;
        sample_tick_i && excite_mode_i == MODE_STABILITY
            |=> overcurrent_count_o - $past(overcurrent_count_o) <= 32'h1;
    endproperty
    a_step: assert property (p_step) else $error("count stepped too far");
    property p_onehot; !(inject_current_o && inject_velocity_o); endproperty
    a_onehot: assert property (p_onehot) else $error("both injections set");
    property p_none; !inject_current_o && !inject_velocity_o |-> peak_amplitude_o == 0; endproperty
    a_none: assert property (p_none) else $error("peak without injection");
    property p_sticky; instability_fault_o && !fault_clear_i |=> instability_fault_o; endproperty
    a_sticky: assert property (p_sticky) else $error("fault dropped");
    property p_cause; $rose(instability_fault_o) |-> $past(excite_mode_i) == MODE_STABILITY;
    endproperty
    a_cause: assert property (p_cause) else $error("fault outside test mode");
    c_fault: cover property (instability_fault_o);
    c_vel: cover property (inject_velocity_o);
    c_read: cover property (reg_rsp_o.rvalid);
endmodule

// file: testbench/test_bode_excitation_stability_monitor.sv
`timescale 1ns/10ps
module test_bode_excitation_stability_monitor;
    import besm_pkg::*;
    logic               clk_i = 0, resetn_i = 0, tick = 0, clr = 0, inj_c, inj_v, flt;
    besm_reg_req_s      req = '0;
    besm_reg_rsp_s      rsp;
    logic [7:0]         mode = 0, code;
    logic signed [15:0] wave = 0;
    logic signed [31:0] cmd = 0, vamp = 32'sh1234, peak, ccmd;
    logic [31:0]        cnt;
    int                 fails = 0, compares = 0, cyc = 0, seed = 7151, amp, e;
    // Clamp limits of the tied current inputs: combined 3000, lower peak 4000
    logic [15:0] ta[6] = '{16'h0510, 16'h0510, 16'h0512, 16'h0512, 16'h002a, 16'h002a};
    int tv[6] = '{0, 70000, 0, 9000, -9000, 9000};
    int te[6] = '{1, 60000, 1, 4000, -3000, 3000};
    always #2.5 clk_i = ~clk_i;
    besm_monitor besm_monitor_inst (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req),
        .reg_rsp_o(rsp), .excite_mode_i(mode), .sample_tick_i(tick), .excite_wave_i(wave),
        .velocity_excite_amplitude_i(vamp), .commanded_current_i(cmd),
        .combined_current_limit_i(32'sd3000), .drive_peak_current_i(32'sd5000),
        .motor_peak_current_i(32'sd4000), .fault_clear_i(clr), .peak_amplitude_o(peak),
        .current_cmd_o(ccmd), .inject_current_o(inj_c), .inject_velocity_o(inj_v),
        .instability_fault_o(flt), .fault_code_o(code), .overcurrent_count_o(cnt));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i) req.we <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        @(posedge clk_i) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i) req.re <= 1'b0;
        #1 chk(32'(rsp.rvalid), 1);
        chk(rsp.rdata, x);
    endtask
    task automatic pulse;
        @(posedge clk_i) tick <= 1;
        @(posedge clk_i) tick <= 0;
        #1;
    endtask
    task automatic stab(input int ms);
        wr(ADDR_OVERCURRENT_DURATION_LIMIT, 32'(ms));
        @(posedge clk_i);
        mode <= MODE_STABILITY;
        cmd <= -32'sd100;
        pulse();
        chk(cnt, 0);
        cmd <= ($random(seed) & 1) ? 32'sd101 : -32'sd150;
        // One extra sample past the limit shows saturation and the fault edge
        for (int i = 0; i <= ms * 16; i++) begin
            pulse();
            chk(cnt, (i < ms * 16) ? i + 1 : ms * 16);
            chk(32'(flt), 32'(i == ms * 16));
        end
        // Clear while the set condition still holds: the set must win
        @(posedge clk_i) clr <= 1;
        @(posedge clk_i) clr <= 0;
        #1 chk(32'(flt), 1);
        chk(32'(code), 32'(FAULT_INSTABILITY));
        @(posedge clk_i) mode <= 0;
        @(posedge clk_i) #1 chk(cnt, 0);
        chk(32'(flt), 1);
        @(posedge clk_i) clr <= 1;
        @(posedge clk_i) clr <= 0;
        #1 chk(32'({flt, code}), 0);
    endtask
    task automatic give_verdict;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1;
        rd(ADDR_CURRENT_EXCITE_AMPLITUDE, 200);
        rd(ADDR_INJECTION_POINT_SELECT, 0);
        rd(ADDR_OVERCURRENT_DURATION_LIMIT, 0);
        rd(ADDR_OVERCURRENT_THRESHOLD, 0);
        rd(16'h0001, 0);
        for (int i = 0; i < 6; i++) begin
            wr(ta[i], tv[i]);
            rd(ta[i], te[i]);
        end
        amp = $random(seed) % 3000;
        wr(ADDR_CURRENT_EXCITE_AMPLITUDE, amp);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_INJECTION_POINT_SELECT, s);
            e = (s < 3) ? s : 2;
            @(posedge clk_i) #1 chk({inj_c, inj_v}, {e == 1, e == 2});
            chk(peak, (e == 1) ? amp : (e == 2) ? vamp : 0);
            rd(ADDR_INJECTION_POINT_SELECT, e);
        end
        wr(ADDR_INJECTION_POINT_SELECT, 1);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            mode <= (i % 2) ? MODE_PRB : 8'h00;
            cmd <= $random(seed) % 4000;
            wave <= 16'($random(seed));
            repeat (2) @(posedge clk_i);
            #1 chk(ccmd, 32'(cmd + ((mode == 1) ? (longint'(amp) * wave) >>> 15 : 0)));
        end
        wr(ADDR_OVERCURRENT_THRESHOLD, 100);
        stab(1);
        stab(2);
        give_verdict();
    end
endmodule
bind besm_monitor besm_monitor_chk besm_monitor_chk_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o),
    .excite_mode_i(excite_mode_i), .sample_tick_i(sample_tick_i),
    .fault_clear_i(fault_clear_i), .peak_amplitude_o(peak_amplitude_o),
    .inject_current_o(inject_current_o), .inject_velocity_o(inject_velocity_o),
    .instability_fault_o(instability_fault_o), .fault_code_o(fault_code_o),
    .overcurrent_count_o(overcurrent_count_o));
